// ===== inc/adcpc_pkg.sv
// package: register map, field positions, reset values and timing counts of the converter control
package adcpc_pkg;

  // ==========================================================
  // register bus
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam logic [2:0] OFS_CTRL0 = 3'h0;
  localparam logic [2:0] OFS_SETUP = 3'h1;
  localparam logic [2:0] OFS_RESULT = 3'h2;
  localparam logic [2:0] OFS_IRQ_EN = 3'h3;
  localparam logic [2:0] OFS_IRQ_FLAG = 3'h4;

  // ==========================================================
  // field positions
  localparam int unsigned CTRL0_CLK_LSB = 6;
  localparam int unsigned CTRL0_CHS_LSB = 3;
  localparam int unsigned CTRL0_GO_BIT = 2;
  localparam int unsigned CTRL0_ON_BIT = 0;
  localparam int unsigned SETUP_CODE_W = 3;
  localparam int unsigned CONV_IRQ_BIT = 6;

  // ==========================================================
  // implemented-bit masks and reset values
  localparam logic [7:0] CTRL0_WMASK = 8'hFD;
  localparam logic [7:0] SETUP_WMASK = 8'h07;
  localparam logic [7:0] IRQ_WMASK = 8'h40;
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] SETUP_RST = 8'h00;
  localparam logic [7:0] IRQ_EN_RST = 8'h00;
  localparam logic [7:0] IRQ_FLAG_RST = 8'h00;

  // ==========================================================
  // conversion clock dividers (count of system clocks per conversion tick, minus one)
  localparam logic [4:0] DIV2_LAST = 5'h01;
  localparam logic [4:0] DIV8_LAST = 5'h07;
  localparam logic [4:0] DIV32_LAST = 5'h1F;
  // conversion ticks per conversion, minus one
  localparam logic [3:0] CONV_TICK_LAST = 4'h9;

  // ==========================================================
  // conversion sequencer states, gray coded
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONV = 2'b01,
    ST_DONE = 2'b11
  } adcpc_state_e;

endpackage

// ===== verilog/adcpc_conv_timer.sv
// file: conversion clock divider and conversion length counter
module adcpc_conv_timer
(
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  input wire logic clk_en_i,
  input wire logic run_i,
  input wire logic [1:0] clk_sel_i,
  output logic done_o
);

  logic [4:0] presc_ff;
  logic [4:0] nxt_presc;
  logic [3:0] tick_cnt_ff;
  logic [3:0] nxt_tick_cnt;
  logic done_ff;
  logic nxt_done;
  logic [4:0] div_last;

  // divider choice; the internal oscillator code falls back to the slowest divider
  always_comb
  begin
    case (clk_sel_i)
      2'b00: div_last = adcpc_pkg::DIV2_LAST;
      2'b01: div_last = adcpc_pkg::DIV8_LAST;
      default: div_last = adcpc_pkg::DIV32_LAST;
    endcase
  end

  // count prescaler and ticks while running, restart when idle
  always_comb
  begin
    nxt_presc = 5'h00;
    nxt_tick_cnt = 4'h0;
    nxt_done = 1'b0;
    if (run_i && !done_ff)
    begin
      nxt_presc = presc_ff + 5'h01;
      nxt_tick_cnt = tick_cnt_ff;
      if (presc_ff >= div_last)
      begin
        nxt_presc = 5'h00;
        nxt_tick_cnt = tick_cnt_ff + 4'h1;
        if (tick_cnt_ff == adcpc_pkg::CONV_TICK_LAST)
        begin
          nxt_tick_cnt = 4'h0;
          nxt_done = 1'b1; // one-cycle end of conversion
        end
      end
    end
  end

  // registers, frozen while the clock enable is low
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      presc_ff <= 5'h00;
      tick_cnt_ff <= 4'h0;
      done_ff <= 1'b0;
    end
    else if (clk_en_i)
    begin
      presc_ff <= nxt_presc;
      tick_cnt_ff <= nxt_tick_cnt;
      done_ff <= nxt_done;
    end
  end

  assign done_o = done_ff;

endmodule

// ===== verilog/adcpc_top.sv
// file: converter control registers, pin role decode, conversion sequencing and interrupt
//
// Contract
// (R01) upper five bits of port setup register read as zero
// (R02) three-bit pin role code in setup bits 2..0, cleared on reset
// (R03) pin role code decides which of four pins are analog or digital
// (R04) codes 0x1 and 101 take reference from channel three pin, else supply
// (R05) software waits an acquisition period after channel change before starting
// (R06) both control registers clear to zero on every reset
// (R07) result register undefined at power-up and unchanged by other resets
// (R08) converter irq enable and flag sit at bit 6, cleared on reset
// (R09) setting start bit starts conversion; hardware clears it on completion
// (R10) converter enable bit low disables converter and its current
// (R11) channel field bits 5..3 selects channels 0..3, higher codes reserved
// (R12) completion writes result and sets sticky irq flag until software clears
//
// Added by the designer: the address map and the plain strobed port.
module adcpc_top
(
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  input wire logic CLK_EN_I,
  input wire logic [2:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  output logic IRQ_O,
  input wire logic [7:0] ANALOG_CODE_I,
  output logic [3:0] PIN_ANALOG_O,
  output logic VREF_FROM_PIN_O,
  output logic CONV_POWER_O,
  output logic [2:0] CHANNEL_SEL_O,
  output logic SAMPLE_HOLD_O
);

  // ==========================================================
  // declarations
  logic [7:0] ctrl0_ff;
  logic [7:0] nxt_ctrl0;
  logic [7:0] setup_ff;
  logic [7:0] nxt_setup;
  logic [7:0] irq_en_ff;
  logic [7:0] nxt_irq_en;
  logic [7:0] irq_flag_ff;
  logic [7:0] nxt_irq_flag;
  logic [7:0] result_ff;
  logic [7:0] nxt_result;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic irq_ff;
  logic nxt_irq;
  adcpc_pkg::adcpc_state_e state_ff;
  adcpc_pkg::adcpc_state_e nxt_state;
  logic [3:0] pin_analog_ff;
  logic [3:0] nxt_pin_analog;
  logic vref_pin_ff;
  logic nxt_vref_pin;
  logic power_ff;
  logic nxt_power;
  logic [2:0] chan_ff;
  logic [2:0] nxt_chan;
  logic sample_ff;
  logic nxt_sample;
  logic [7:0] code_meta_ff;
  logic [7:0] code_sync_ff;
  logic conv_done;
  logic timer_run;
  logic wr_ctrl0;
  logic wr_setup;
  logic wr_irq_en;
  logic wr_irq_flag;
  logic [2:0] role_code;

  // ==========================================================
  // write decode
  assign wr_ctrl0 = REG_WR_I && (REG_ADDR_I == adcpc_pkg::OFS_CTRL0);
  assign wr_setup = REG_WR_I && (REG_ADDR_I == adcpc_pkg::OFS_SETUP);
  assign wr_irq_en = REG_WR_I && (REG_ADDR_I == adcpc_pkg::OFS_IRQ_EN);
  assign wr_irq_flag = REG_WR_I && (REG_ADDR_I == adcpc_pkg::OFS_IRQ_FLAG);
  assign role_code = nxt_setup[adcpc_pkg::SETUP_CODE_W-1:0];

  // ==========================================================
  // analog code from the converter macro crosses in through two flops
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      code_meta_ff <= 8'h00;
      code_sync_ff <= 8'h00;
    end
    else if (CLK_EN_I)
    begin
      code_meta_ff <= ANALOG_CODE_I;
      code_sync_ff <= code_meta_ff;
    end
  end

  // ==========================================================
  // conversion length timer
  assign timer_run = (state_ff == adcpc_pkg::ST_CONV) && ctrl0_ff[adcpc_pkg::CTRL0_GO_BIT];

  adcpc_conv_timer u_timer
  (
    .CLK_SYS_I(CLK_SYS_I),
    .RESET_I(RESET_I),
    .clk_en_i(CLK_EN_I),
    .run_i(timer_run),
    .clk_sel_i(ctrl0_ff[adcpc_pkg::CTRL0_CLK_LSB +: 2]),
    .done_o(conv_done)
  );

  // ==========================================================
  // control registers and conversion sequencer
  always_comb
  begin
    nxt_ctrl0 = ctrl0_ff;
    nxt_setup = setup_ff;
    nxt_irq_en = irq_en_ff;
    nxt_state = state_ff;
    // software writes only implemented bits; the rest stay zero
    if (wr_ctrl0)
    begin
      nxt_ctrl0 = REG_WDATA_I & adcpc_pkg::CTRL0_WMASK; // [R11]
    end
    if (wr_setup)
    begin
      nxt_setup = REG_WDATA_I & adcpc_pkg::SETUP_WMASK; // [R01] [R02]
    end
    if (wr_irq_en)
    begin
      nxt_irq_en = REG_WDATA_I & adcpc_pkg::IRQ_WMASK; // [R08]
    end
    // a start with the converter off is dropped at once
    if (!nxt_ctrl0[adcpc_pkg::CTRL0_ON_BIT])
    begin
      nxt_ctrl0[adcpc_pkg::CTRL0_GO_BIT] = 1'b0; // [R10]
    end
    case (state_ff)
      adcpc_pkg::ST_IDLE:
      begin
        if (ctrl0_ff[adcpc_pkg::CTRL0_GO_BIT])
        begin
          nxt_state = adcpc_pkg::ST_CONV; // [R09]
        end
      end
      adcpc_pkg::ST_CONV:
      begin
        if (!ctrl0_ff[adcpc_pkg::CTRL0_GO_BIT])
        begin
          nxt_state = adcpc_pkg::ST_IDLE; // aborted by software or power-down
        end
        else if (conv_done)
        begin
          nxt_ctrl0[adcpc_pkg::CTRL0_GO_BIT] = 1'b0; // [R09]
          nxt_state = adcpc_pkg::ST_DONE;
        end
      end
      adcpc_pkg::ST_DONE:
      begin
        nxt_state = adcpc_pkg::ST_IDLE;
      end
      default:
      begin
        nxt_state = adcpc_pkg::ST_IDLE;
      end
    endcase
  end

  // control registers clear on every reset
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      ctrl0_ff <= adcpc_pkg::CTRL0_RST; // [R06]
      setup_ff <= adcpc_pkg::SETUP_RST; // [R06] [R02]
      irq_en_ff <= adcpc_pkg::IRQ_EN_RST; // [R08]
      state_ff <= adcpc_pkg::ST_IDLE;
    end
    else if (CLK_EN_I)
    begin
      ctrl0_ff <= nxt_ctrl0;
      setup_ff <= nxt_setup;
      irq_en_ff <= nxt_irq_en;
      state_ff <= nxt_state;
    end
  end

  // ==========================================================
  // result capture and sticky interrupt flag
  always_comb
  begin
    nxt_result = result_ff;
    nxt_irq_flag = irq_flag_ff;
    // writing one clears the flag
    if (wr_irq_flag)
    begin
      nxt_irq_flag = irq_flag_ff & ~(REG_WDATA_I & adcpc_pkg::IRQ_WMASK);
    end
    // completion wins over a clear in the same cycle
    if ((state_ff == adcpc_pkg::ST_CONV) && ctrl0_ff[adcpc_pkg::CTRL0_GO_BIT] && conv_done)
    begin
      nxt_result = code_sync_ff; // [R12]
      nxt_irq_flag[adcpc_pkg::CONV_IRQ_BIT] = 1'b1; // [R12]
    end
    nxt_irq = |(nxt_irq_flag & nxt_irq_en);
  end

  // result has no reset so it survives every reset
  always_ff @(posedge CLK_SYS_I)
  begin
    if (CLK_EN_I)
    begin
      result_ff <= nxt_result; // [R07]
    end
  end

  // flag and interrupt line
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      irq_flag_ff <= adcpc_pkg::IRQ_FLAG_RST; // [R08]
      irq_ff <= 1'b0;
    end
    else if (CLK_EN_I)
    begin
      irq_flag_ff <= nxt_irq_flag;
      irq_ff <= nxt_irq;
    end
  end

  // ==========================================================
  // pin roles, reference choice and converter controls
  always_comb
  begin
    // channels 0 and 1 go digital only for codes 11x
    nxt_pin_analog[0] = ~(role_code[2] & role_code[1]); // [R03]
    nxt_pin_analog[1] = ~(role_code[2] & role_code[1]); // [R03]
    // channel 2 is digital whenever the top code bit is set
    nxt_pin_analog[2] = ~role_code[2]; // [R03]
    // channel 3 is analog for 0x0 and 100, reference or digital otherwise
    nxt_pin_analog[3] = ~role_code[0] & ~(role_code[2] & role_code[1]); // [R03] [R04]
    nxt_vref_pin = role_code[0] & ~(role_code[2] & role_code[1]); // [R04]
    nxt_power = nxt_ctrl0[adcpc_pkg::CTRL0_ON_BIT]; // [R10]
    nxt_chan = nxt_ctrl0[adcpc_pkg::CTRL0_CHS_LSB +: 3]; // [R11]
    // sampling capacitor tracks the channel while powered, except while converting
    nxt_sample = nxt_power && (nxt_state != adcpc_pkg::ST_CONV); // [R05]
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      pin_analog_ff <= 4'hF;
      vref_pin_ff <= 1'b0;
      power_ff <= 1'b0;
      chan_ff <= 3'h0;
      sample_ff <= 1'b0;
    end
    else if (CLK_EN_I)
    begin
      pin_analog_ff <= nxt_pin_analog;
      vref_pin_ff <= nxt_vref_pin;
      power_ff <= nxt_power;
      chan_ff <= nxt_chan;
      sample_ff <= nxt_sample;
    end
  end

  // ==========================================================
  // read data, valid only in the cycle after the read strobe
  always_comb
  begin
    nxt_rdata = 8'h00;
    if (REG_RD_I)
    begin
      case (REG_ADDR_I)
        adcpc_pkg::OFS_CTRL0: nxt_rdata = ctrl0_ff;
        adcpc_pkg::OFS_SETUP: nxt_rdata = setup_ff & adcpc_pkg::SETUP_WMASK; // [R01]
        adcpc_pkg::OFS_RESULT: nxt_rdata = result_ff;
        adcpc_pkg::OFS_IRQ_EN: nxt_rdata = irq_en_ff;
        adcpc_pkg::OFS_IRQ_FLAG: nxt_rdata = irq_flag_ff;
        default: nxt_rdata = 8'h00; // unmapped reads zero
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (RESET_I)
    begin
      rdata_ff <= 8'h00;
    end
    else if (CLK_EN_I)
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign REG_RDATA_O = rdata_ff;
  assign IRQ_O = irq_ff;
  assign PIN_ANALOG_O = pin_analog_ff;
  assign VREF_FROM_PIN_O = vref_pin_ff;
  assign CONV_POWER_O = power_ff;
  assign CHANNEL_SEL_O = chan_ff;
  assign SAMPLE_HOLD_O = sample_ff;

endmodule

// ===== verif/adcpc_monitor.sv
// checker: bus, pin role, power and interrupt relations at the top ports
module adcpc_monitor
(
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  input wire logic [2:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_RDATA_O,
  input wire logic IRQ_O,
  input wire logic [3:0] PIN_ANALOG_O,
  input wire logic VREF_FROM_PIN_O,
  input wire logic CONV_POWER_O,
  input wire logic [2:0] CHANNEL_SEL_O,
  input wire logic SAMPLE_HOLD_O
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wr_setup;
  logic wr_ctrl;
  // ==========
  // decoded write strobes
  assign wr_setup = REG_WR_I && (REG_ADDR_I == adcpc_pkg::OFS_SETUP);
  assign wr_ctrl = REG_WR_I && (REG_ADDR_I == adcpc_pkg::OFS_CTRL0);
  default clocking @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RESET_I);
  // ==========
  // bus answers
  AST_RDATA_IDLE: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 8'h00)
    else $error("read data outside read slot");
  AST_SETUP_HIGH: assert property ($past(REG_RD_I) && $past(REG_ADDR_I) == adcpc_pkg::OFS_SETUP |-> REG_RDATA_O[7:3] == 5'h00)
    else $error("setup upper bits not zero");
  AST_IRQ_BITS: assert property ($past(REG_RD_I) && $past(REG_ADDR_I) >= adcpc_pkg::OFS_IRQ_EN |-> (REG_RDATA_O & 8'hBF) == 8'h00)
    else $error("irq register bit other than 6 set");
  AST_IRQ_FLAG: assert property (IRQ_O && REG_RD_I && REG_ADDR_I == adcpc_pkg::OFS_IRQ_FLAG |=> REG_RDATA_O[6])
    else $error("irq high but flag reads clear");
  // ==========
  // pin roles, reference, power and channel after writes, and outputs after reset
  AST_ROLE_DIGITAL: assert property (wr_setup && REG_WDATA_I[2:1] == 2'b11 |-> ##2 PIN_ANALOG_O == 4'h0 && !VREF_FROM_PIN_O)
    else $error("code 11x not all digital");
  AST_ROLE_100: assert property (wr_setup && REG_WDATA_I[2:0] == 3'b100 |-> ##2 PIN_ANALOG_O == 4'hB)
    else $error("code 100 wrong roles");
  AST_VREF_PIN: assert property (wr_setup && REG_WDATA_I[0] && REG_WDATA_I[2:1] != 2'b11 |-> ##2 VREF_FROM_PIN_O)
    else $error("reference not from pin");
  AST_POWER_OFF: assert property (wr_ctrl && !REG_WDATA_I[0] |-> ##2 !CONV_POWER_O && !SAMPLE_HOLD_O)
    else $error("converter still powered");
  AST_CHANNEL: assert property (wr_ctrl && REG_WDATA_I[5:3] == 3'h3 |-> ##2 CHANNEL_SEL_O == 3'h3)
    else $error("channel three not selected");
  AST_RESET_OUT: assert property (disable iff (1'b0) RESET_I |=> !CONV_POWER_O && CHANNEL_SEL_O == 3'h0 && !IRQ_O)
    else $error("outputs not cleared by reset");
endmodule

bind adcpc_top adcpc_monitor u_monitor
(
  .CLK_SYS_I(CLK_SYS_I),
  .RESET_I(RESET_I),
  .REG_ADDR_I(REG_ADDR_I),
  .REG_WDATA_I(REG_WDATA_I),
  .REG_WR_I(REG_WR_I),
  .REG_RD_I(REG_RD_I),
  .REG_RDATA_O(REG_RDATA_O),
  .IRQ_O(IRQ_O),
  .PIN_ANALOG_O(PIN_ANALOG_O),
  .VREF_FROM_PIN_O(VREF_FROM_PIN_O),
  .CONV_POWER_O(CONV_POWER_O),
  .CHANNEL_SEL_O(CHANNEL_SEL_O),
  .SAMPLE_HOLD_O(SAMPLE_HOLD_O)
);

// ===== verif/adcpc_analog_src.sv
// model: analog source giving one code per selected channel
module adcpc_analog_src
(
  input wire logic clk_i,
  input wire logic power_i,
  input wire logic [2:0] channel_i,
  output logic [7:0] code_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic flip_ff = 1'b0;
  // ==========
  // steady level while powered, toggling junk while off
  always @(posedge clk_i)
    flip_ff <= ~flip_ff;
  assign code_o = power_i ? (8'hA0 | {5'h00, channel_i}) : {8{flip_ff}};
endmodule

// ===== verif/test_adc_port_config_control.sv
// testbench: registers, pin roles, conversions and interrupt of the converter control
module test_adc_port_config_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys;
  logic reset;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic irq;
  logic [7:0] code;
  logic [3:0] pins;
  logic vref;
  logic power;
  logic [2:0] chan;
  logic hold;
  int num_errors = 0;
  int comparisons = 0;
  // ==========
  // design and analog source
  adcpc_top DUT
  (
    .CLK_SYS_I(clk_sys),
    .RESET_I(reset),
    .CLK_EN_I(1'b1),
    .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata),
    .REG_WR_I(wr),
    .REG_RD_I(rd),
    .REG_RDATA_O(rdata),
    .IRQ_O(irq),
    .ANALOG_CODE_I(code),
    .PIN_ANALOG_O(pins),
    .VREF_FROM_PIN_O(vref),
    .CONV_POWER_O(power),
    .CHANNEL_SEL_O(chan),
    .SAMPLE_HOLD_O(hold)
  );
  adcpc_analog_src u_src
  (
    .clk_i(clk_sys),
    .power_i(power),
    .channel_i(chan),
    .code_o(code)
  );
  // ==========
  // bus and compare helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd_reg(a, d);
    chk(d, e);
  endtask
  // ==========
  // scenarios
  task automatic t_reset_values;
    rd_chk(adcpc_pkg::OFS_CTRL0, 8'h00);
    rd_chk(adcpc_pkg::OFS_SETUP, 8'h00);
    rd_chk(adcpc_pkg::OFS_IRQ_EN, 8'h00);
    rd_chk(adcpc_pkg::OFS_IRQ_FLAG, 8'h00);
    chk({4'h0, pins}, 8'h0F);
    $display("test reset values done");
  endtask
  task automatic t_pin_roles;
    logic [3:0] ep;
    logic ev;
    for (int c = 0; c < 8; c++)
    begin
      wr_reg(adcpc_pkg::OFS_SETUP, 8'hF8 | 8'(c));
      rd_chk(adcpc_pkg::OFS_SETUP, 8'(c));
      ev = c[0] && (c[2:1] != 2'b11);
      ep = (c[2:1] == 2'b11) ? 4'h0 : (c[2] ? 4'hB : 4'hF);
      // the reference pin is no longer an analog input
      if (ev)
        ep[3] = 1'b0;
      chk({4'h0, pins}, {4'h0, ep});
      chk({7'h00, vref}, {7'h00, ev});
    end
    wr_reg(adcpc_pkg::OFS_SETUP, 8'h00);
    $display("test pin roles done");
  endtask
  task automatic t_convert;
    logic [7:0] d;
    wr_reg(adcpc_pkg::OFS_IRQ_EN, 8'h40);
    for (int ch = 0; ch < 4; ch++)
    begin
      wr_reg(adcpc_pkg::OFS_CTRL0, {ch[1:0], 1'b0, ch[1:0], 3'b001});
      repeat (20) @(posedge clk_sys);
      // powered, tracking and pointing at the chosen channel
      chk({3'h0, power, hold, chan}, {3'h0, 2'b11, 1'b0, ch[1:0]});
      wr_reg(adcpc_pkg::OFS_CTRL0, {ch[1:0], 1'b0, ch[1:0], 3'b101});
      @(posedge clk_sys);
      #1 chk({7'h00, hold}, 8'h00);
      d = 8'h04;
      for (int i = 0; i < 400 && d[2]; i++)
        rd_reg(adcpc_pkg::OFS_CTRL0, d);
      chk(d, {ch[1:0], 1'b0, ch[1:0], 3'b001});
      rd_chk(adcpc_pkg::OFS_RESULT, 8'hA0 | 8'(ch));
      rd_chk(adcpc_pkg::OFS_IRQ_FLAG, 8'h40);
      chk({6'h00, hold, irq}, 8'h03);
      wr_reg(adcpc_pkg::OFS_IRQ_EN, 8'h00);
      @(posedge clk_sys);
      #1 chk({7'h00, irq}, 8'h00);
      wr_reg(adcpc_pkg::OFS_IRQ_EN, 8'h40);
      @(posedge clk_sys);
      #1 chk({7'h00, irq}, 8'h01);
      wr_reg(adcpc_pkg::OFS_IRQ_FLAG, 8'h40);
      rd_chk(adcpc_pkg::OFS_IRQ_FLAG, 8'h00);
    end
    $display("test convert done");
  endtask
  task automatic t_abort_reset;
    wr_reg(adcpc_pkg::OFS_CTRL0, 8'h01);
    repeat (20) @(posedge clk_sys);
    wr_reg(adcpc_pkg::OFS_CTRL0, 8'h05);
    repeat (3) @(posedge clk_sys);
    wr_reg(adcpc_pkg::OFS_CTRL0, 8'h00);
    repeat (400) @(posedge clk_sys);
    rd_chk(adcpc_pkg::OFS_IRQ_FLAG, 8'h00);
    rd_chk(adcpc_pkg::OFS_RESULT, 8'hA3);
    chk({6'h00, power, hold}, 8'h00);
    wr_reg(adcpc_pkg::OFS_CTRL0, 8'hD9);
    wr_reg(adcpc_pkg::OFS_SETUP, 8'h05);
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    rd_chk(adcpc_pkg::OFS_RESULT, 8'hA3);
    rd_chk(adcpc_pkg::OFS_CTRL0, 8'h00);
    rd_chk(adcpc_pkg::OFS_SETUP, 8'h00);
    $display("test abort and reset done");
  endtask
  // ==========
  // verdict
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========
  // clock, watchdog and main sequence
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial
  begin
    #2000000;
    num_errors++;
    test_done();
  end
  initial
  begin
    reset = 1'b1;
    addr = 3'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset_values();
    t_pin_roles();
    t_convert();
    t_abort_reset();
    test_done();
  end
endmodule
